//--- src/cprd_consts.svh
`ifndef CPRD_CONSTS_SVH
`define CPRD_CONSTS_SVH

// Record number that carries the channel parameters
`define CPRD_RECORD_NUM    16'h0080
// Expected parameter data length, 48 bytes
`define CPRD_PARAM_LEN     8'h30
// Format version byte: major 0 high nibble, minor 1 low nibble
`define CPRD_VERSION       8'h01
// Value expected in the two spare header bytes
`define CPRD_SPARE_VAL     8'h00

// Byte offsets inside the record
`define CPRD_OFS_VERSION   8'h00
`define CPRD_OFS_LENGTH    8'h01
`define CPRD_OFS_SPARE_A   8'h02
`define CPRD_OFS_SPARE_B   8'h03
`define CPRD_OFS_FUNC      8'h04
`define CPRD_OFS_BASIC     8'h05
`define CPRD_OFS_INPUT     8'h06

// Field positions
`define CPRD_FUNC_RANGE    3:0
`define CPRD_FUNC_RSVD     7:4
`define CPRD_STOP_RANGE    1:0
`define CPRD_SENS_RANGE    7:6
`define CPRD_EVAL_RANGE    5:4
`define CPRD_SIGT_RANGE    3:0

// Field encodings
`define CPRD_FUNC_COUNT    4'h1
`define CPRD_FUNC_MEASURE  4'h2
`define CPRD_FUNC_RSVD_VAL 4'h0
`define CPRD_STOP_HOLD     2'h1
`define CPRD_STOP_CONT     2'h2
`define CPRD_SENS_RSVD     2'h3
`define CPRD_EVAL_RSVD     2'h3
`define CPRD_SIGT_MAX      4'h4

// Status error codes
`define CPRD_ERR_NONE      8'h00
`define CPRD_ERR_RECORD    8'hB0
`define CPRD_ERR_LENGTH    8'hB1
`define CPRD_ERR_HEADER    8'hB2
`define CPRD_ERR_VALUE     8'hB3
`define CPRD_ERR_MODE      8'hB4

// Reset values
`define CPRD_CFG_RESET     14'h0000
`define CPRD_CNT_RESET     8'h00

`endif

//--- src/cprd_pkg.sv
package cprd_pkg;

	// Receiver state
	typedef enum logic
	{
		CPRD_IDLE,
		CPRD_RECV
	} cprd_state_e;

	// Applied channel configuration
	typedef struct packed
	{
		logic [3:0] func_mode;   // Counting or measuring
		logic [1:0] stop_react;  // Reaction to controller stop
		logic [1:0] sensor;      // Sensor output type
		logic [1:0] eval;        // Edge evaluation multiplier
		logic [3:0] sig_type;    // Input signal type
	} cprd_cfg_s;

	// Answer to one record write
	typedef struct packed
	{
		logic       valid;       // One-cycle answer strobe
		logic       error;       // Transfer refused
		logic [7:0] code;        // Byte count or error code
	} cprd_status_s;

endpackage

//--- src/cprd_top.sv
// How it works
// - Accept record 128 writes while running.
// - Faulty transfer keeps old config, reports code.
// - Good transfer reports transferred byte count.
// - Mode byte changes only at fresh assignment or before the first applied config.
// - Header version 0.1, length 48, spares.
// - Mode nibble: counting or measuring.
// - Stop reaction: hold last or continue.
// - Sensor type from byte 6 bits 7..6.
// - Edge evaluation from byte 6 bits 5..4.
// - Signal type from byte 6 low nibble.
`timescale 1ns/1ns
`include "cprd_consts.svh"

module cprd_top
	import cprd_pkg::*;
(
	input  wire logic         CLK,
	input  wire logic         RESET_N,
	input  wire logic         REC_START,
	input  wire logic [15:0]  REC_INDEX,
	input  wire logic         REC_VALID,
	input  wire logic [7:0]   REC_DATA,
	input  wire logic         REC_END,
	input  wire logic         FRESH_ASSIGN,
	output cprd_status_s      STATUS,
	output cprd_cfg_s         CFG,
	output logic              CFG_VALID
);

	// Reset synchroniser stages
	logic          rst_meta_r;     // First stage, read only by second
	logic          rst_n_r;        // Released reset used everywhere

	// Receiver state
	cprd_state_e   state_r;        // Idle or inside a record
	cprd_state_e   state_nxt;
	logic [7:0]    byte_cnt_r;     // Bytes taken in this record
	logic [7:0]    byte_cnt_nxt;
	logic [7:0]    err_code_r;     // First error seen in this record
	logic [7:0]    err_code_nxt;
	cprd_cfg_s     stage_r;        // Staged fields, not yet applied
	cprd_cfg_s     stage_nxt;

	// Applied configuration and answer
	cprd_cfg_s     cfg_r;
	cprd_cfg_s     cfg_nxt;
	logic          cfg_valid_r;
	logic          cfg_valid_nxt;
	cprd_status_s  status_r;
	cprd_status_s  status_nxt;

	// Release reset through two flops so removal is clean
	// Assertion stays asynchronous; only the release waits
	// Two edges of delay keep removal off a metastable edge
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// Transfer events; a new start always wins and restarts
	// Start honoured in any state, so a cut record is dropped
	// Valid or end outside a record ignored, no answer given
	wire           in_recv    = (state_r == CPRD_RECV);
	wire           take_start = REC_START;
	wire           take_byte  = in_recv && REC_VALID && !REC_START && !REC_END;
	wire           take_end   = in_recv && REC_END && !REC_START;
	wire           index_bad  = (REC_INDEX != `CPRD_RECORD_NUM);

	// Offset decode of the incoming byte
	// Offset is the count of bytes taken, first byte at zero
	// One compare per field keeps the decode paths short
	wire           at_ver     = (byte_cnt_r == `CPRD_OFS_VERSION);
	wire           at_len     = (byte_cnt_r == `CPRD_OFS_LENGTH);
	wire           at_spare   = (byte_cnt_r == `CPRD_OFS_SPARE_A) || (byte_cnt_r == `CPRD_OFS_SPARE_B);
	wire           at_func    = (byte_cnt_r == `CPRD_OFS_FUNC);
	wire           at_basic   = (byte_cnt_r == `CPRD_OFS_BASIC);
	wire           at_input   = (byte_cnt_r == `CPRD_OFS_INPUT);
	wire           too_many   = (byte_cnt_r >= `CPRD_PARAM_LEN);

	// Field slices of the incoming byte
	// Plain wires; only used when the offset matches
	wire [3:0]     func_f     = REC_DATA[`CPRD_FUNC_RANGE];
	wire [3:0]     func_rsvd  = REC_DATA[`CPRD_FUNC_RSVD];
	wire [1:0]     stop_f     = REC_DATA[`CPRD_STOP_RANGE];
	wire [1:0]     sens_f     = REC_DATA[`CPRD_SENS_RANGE];
	wire [1:0]     eval_f     = REC_DATA[`CPRD_EVAL_RANGE];
	wire [3:0]     sigt_f     = REC_DATA[`CPRD_SIGT_RANGE];

	// Header must match the fixed format exactly
	// Fixed version, length and zero spares; anything else refused
	// Stops a record of another layout being half applied
	wire           ver_bad    = at_ver && (REC_DATA != `CPRD_VERSION);
	wire           len_bad    = at_len && (REC_DATA != `CPRD_PARAM_LEN);
	wire           spare_bad  = at_spare && (REC_DATA != `CPRD_SPARE_VAL);
	wire           hdr_bad    = ver_bad || len_bad || spare_bad;

	// Mode: only counting or measuring, upper nibble spare
	// Upper nibble must be zero so future codes are not misread
	// Zero and codes above two refused as reserved
	wire           func_ok    = (func_f == `CPRD_FUNC_COUNT) || (func_f == `CPRD_FUNC_MEASURE);
	wire           func_bad   = at_func && (!func_ok || (func_rsvd != `CPRD_FUNC_RSVD_VAL));

	// Mode may not move while running with a live config
	// Compared against the applied mode, not the staged one
	// Before the first applied record there is nothing to lock
	// Sampled when byte 4 is taken; later level changes do not count
	wire           func_moved = (func_f != cfg_r.func_mode);
	wire           func_lock  = at_func && cfg_valid_r && !FRESH_ASSIGN && func_moved;

	// Stop reaction: unlisted 00 treated as reserved too
	// Bits above the low two ignored on purpose
	// Refusing 00 avoids an undefined stop reaction
	wire           stop_ok    = (stop_f == `CPRD_STOP_HOLD) || (stop_f == `CPRD_STOP_CONT);
	wire           basic_bad  = at_basic && !stop_ok;

	// Counter inputs: reserved codes refused
	// Sensor and evaluation refuse 11; signal type refuses above 4
	// All three checked together, one code for the byte
	wire           sens_bad   = (sens_f == `CPRD_SENS_RSVD);
	wire           eval_bad   = (eval_f == `CPRD_EVAL_RSVD);
	wire           sigt_bad   = (sigt_f > `CPRD_SIGT_MAX);
	wire           input_bad  = at_input && (sens_bad || eval_bad || sigt_bad);

	// Error for this byte, most basic fault first
	// Priority: length, header, mode lock, then value
	// Mode lock wins over a reserved mode in the same byte
	// Only one code fits the answer, so the order is fixed
	wire           value_bad  = func_bad || basic_bad || input_bad;
	wire [7:0]     byte_code  = too_many  ? `CPRD_ERR_LENGTH :
	                            hdr_bad   ? `CPRD_ERR_HEADER :
	                            func_lock ? `CPRD_ERR_MODE   :
	                            value_bad ? `CPRD_ERR_VALUE  :
	                                        `CPRD_ERR_NONE;

	// Keep the first fault; later bytes cannot hide it
	// Error code register doubles as the sticky fault marker
	// Cleared only by a new start, never by a later byte
	wire           had_err    = (err_code_r != `CPRD_ERR_NONE);
	wire [7:0]     keep_code  = had_err ? err_code_r : byte_code;

	// Verdict at the end of the record
	// Short record counts as a length fault at the end
	// A long record was already flagged at byte 48
	// Apply needs a clean end; anything else keeps the old set
	wire           short_rec  = (byte_cnt_r != `CPRD_PARAM_LEN);
	wire [7:0]     final_code = had_err   ? err_code_r :
	                            short_rec ? `CPRD_ERR_LENGTH :
	                                        `CPRD_ERR_NONE;
	wire           final_bad  = (final_code != `CPRD_ERR_NONE);
	wire           apply      = take_end && !final_bad;

	// Count saturates so an endless stream cannot wrap to 48
	// Limitation: count cannot show more than 255 bytes
	// Only reached by a stream far beyond any legal record
	wire           cnt_full   = (byte_cnt_r == 8'hFF);
	wire [7:0]     cnt_inc    = cnt_full ? byte_cnt_r : byte_cnt_r + 8'h01;

	// Next state of the receiver
	// Two states: waiting for start, or inside a record
	// End returns to idle; start from either state restarts
	always_comb
	begin
		state_nxt = state_r;
		if (take_start)
		begin
			state_nxt = CPRD_RECV;
		end
		else if (take_end)
		begin
			state_nxt = CPRD_IDLE;
		end
	end

	// Byte counter and first-error tracking
	// Counter moves only on accepted bytes, never on stalls
	// Bad record number caught at start, before any byte
	always_comb
	begin
		byte_cnt_nxt = byte_cnt_r;
		err_code_nxt = err_code_r;
		if (take_start)
		begin
			// Wrong record number poisons the whole transfer
			byte_cnt_nxt = `CPRD_CNT_RESET;
			err_code_nxt = index_bad ? `CPRD_ERR_RECORD : `CPRD_ERR_NONE;
		end
		else if (take_byte)
		begin
			byte_cnt_nxt = cnt_inc;
			err_code_nxt = keep_code;
		end
	end

	// Stage decoded fields; nothing reaches CFG before the end
	// Staging costs fourteen flops but keeps CFG stable mid-record
	// A refused record leaves staged values that are never applied
	always_comb
	begin
		stage_nxt = stage_r;
		if (take_byte && at_func)
		begin
			stage_nxt.func_mode = func_f;
		end
		if (take_byte && at_basic)
		begin
			stage_nxt.stop_react = stop_f;
		end
		if (take_byte && at_input)
		begin
			stage_nxt.sensor   = sens_f;
			stage_nxt.eval     = eval_f;
			stage_nxt.sig_type = sigt_f;
		end
	end

	// Apply staged config only on a clean record
	// CFG and CFG_VALID move on the same edge as the answer
	// Valid flag never cleared except by reset
	always_comb
	begin
		cfg_nxt       = cfg_r;
		cfg_valid_nxt = cfg_valid_r;
		if (apply)
		begin
			cfg_nxt       = stage_r;
			cfg_valid_nxt = 1'b1;
		end
	end

	// Answer: byte count on success, code on failure
	// Strobe for exactly one cycle after the end is taken
	// Error flag and code hold until the next answer
	// Success code is the count, 48 on any clean record
	always_comb
	begin
		status_nxt       = status_r;
		status_nxt.valid = 1'b0;
		if (take_end)
		begin
			status_nxt.valid = 1'b1;
			status_nxt.error = final_bad;
			status_nxt.code  = final_bad ? final_code : byte_cnt_r;
		end
	end

	// Receiver registers
	// Async reset by the released copy, constants only
	// State, count, fault and staged fields clear together
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			state_r    <= CPRD_IDLE;
			byte_cnt_r <= `CPRD_CNT_RESET;
			err_code_r <= `CPRD_ERR_NONE;
			stage_r    <= `CPRD_CFG_RESET;
		end
		else
		begin
			state_r    <= state_nxt;
			byte_cnt_r <= byte_cnt_nxt;
			err_code_r <= err_code_nxt;
			stage_r    <= stage_nxt;
		end
	end

	// Applied configuration and answer registers
	// Kept apart from the receiver so the applied set is easy to find
	// Reset leaves no config valid; CFG reads as all zero
	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			cfg_r       <= `CPRD_CFG_RESET;
			cfg_valid_r <= 1'b0;
			status_r    <= '0;
		end
		else
		begin
			cfg_r       <= cfg_nxt;
			cfg_valid_r <= cfg_valid_nxt;
			status_r    <= status_nxt;
		end
	end

	// Outputs straight from flops
	// No logic between flops and pins keeps output timing clean
	// Struct ports keep field order identical to the package
	assign STATUS    = status_r;
	assign CFG       = cfg_r;
	assign CFG_VALID = cfg_valid_r;

endmodule

//--- verification/cprd_top_checker.sv
`timescale 1ns/1ns
module cprd_top_checker
	import cprd_pkg::*;
(
	input wire logic         CLK,
	input wire logic         RESET_N,
	input wire logic         REC_START,
	input wire logic [15:0]  REC_INDEX,
	input wire logic         REC_VALID,
	input wire logic [7:0]   REC_DATA,
	input wire logic         REC_END,
	input wire logic         FRESH_ASSIGN,
	input wire cprd_status_s STATUS,
	input wire cprd_cfg_s    CFG,
	input wire logic         CFG_VALID
);
	// One clock domain, so clocking and reset are stated once
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// Accepted answer
	sequence s_good;
		STATUS.valid && !STATUS.error;
	endsequence
	valid_pulse_a: assert property (STATUS.valid |=> !STATUS.valid) else $error("answer strobe too long");
	answer_cause_a: assert property (STATUS.valid |-> $past(REC_END)) else $error("answer without end");
	cfg_hold_a: assert property ($changed(CFG) |-> s_good) else $error("config moved without ok");
	cfgv_rise_a: assert property ($rose(CFG_VALID) |-> s_good) else $error("config flag without ok");
	cfgv_keep_a: assert property (CFG_VALID |=> CFG_VALID) else $error("config flag dropped");
	ok_count_a: assert property (s_good |-> STATUS.code == 8'h30 && CFG_VALID) else $error("bad byte count");
	err_code_a: assert property (STATUS.valid && STATUS.error |-> STATUS.code inside {[8'hB0:8'hB4]})
		else $error("bad error code");
	cfg_legal_a: assert property (s_good |-> CFG.func_mode inside {4'h1, 4'h2}
		&& CFG.stop_react inside {2'h1, 2'h2} && CFG.sensor != 2'h3 && CFG.eval != 2'h3 && CFG.sig_type <= 4'h4)
		else $error("reserved code applied");
	code_stand_a: assert property (!STATUS.valid |-> $stable(STATUS.code)) else $error("code did not hold");
	mode_lock_a: assert property ($changed(CFG.func_mode) && $past(CFG_VALID) |-> $past(FRESH_ASSIGN))
		else $error("mode moved while running");
endmodule
bind cprd_top cprd_top_checker u_cprd_top_checker (.CLK(CLK), .RESET_N(RESET_N), .REC_START(REC_START),
	.REC_INDEX(REC_INDEX), .REC_VALID(REC_VALID), .REC_DATA(REC_DATA), .REC_END(REC_END),
	.FRESH_ASSIGN(FRESH_ASSIGN), .STATUS(STATUS), .CFG(CFG), .CFG_VALID(CFG_VALID));

//--- verification/cprd_ctrl_model.sv
`timescale 1ns/1ns
module cprd_ctrl_model
(
	input  wire logic  CLK,
	output logic       REC_START,
	output logic [15:0] REC_INDEX,
	output logic       REC_VALID,
	output logic [7:0] REC_DATA,
	output logic       REC_END
);
	initial {REC_START, REC_INDEX, REC_VALID, REC_DATA, REC_END} = '0;
	// One record write; idle data shows the inverse so stale bytes never look valid
	task automatic write_rec(input logic [15:0] idx, input logic [7:0] hb[7], input int n, input int stall);
		@(posedge CLK);
		REC_START <= 1'b1;
		REC_INDEX <= idx;
		for (int i = 0; i < n; i++)
		begin
			// Mid-record stall of the writer
			for (int j = 0; j < stall && i == n / 2; j++)
			begin
				@(posedge CLK);
				REC_VALID <= 1'b0;
				REC_DATA  <= ~REC_DATA;
			end
			@(posedge CLK);
			REC_START <= 1'b0;
			REC_INDEX <= ~idx;
			REC_VALID <= 1'b1;
			REC_DATA  <= (i < 7) ? hb[i] : 8'($urandom);
		end
		@(posedge CLK);
		REC_VALID <= 1'b0;
		REC_DATA  <= ~REC_DATA;
		REC_END   <= 1'b1;
		@(posedge CLK);
		REC_END   <= 1'b0;
	endtask
	// Stray byte and end while idle, then a record cut short with no end
	task automatic stray_cut(input logic [7:0] b);
		@(posedge CLK);
		REC_VALID <= 1'b1;
		REC_DATA  <= b;
		REC_END   <= 1'b1;
		@(posedge CLK);
		REC_VALID <= 1'b0;
		REC_END   <= 1'b0;
		REC_START <= 1'b1;
		REC_INDEX <= 16'h0081;
		@(posedge CLK);
		REC_START <= 1'b0;
		REC_VALID <= 1'b1;
		REC_DATA  <= ~b;
		@(posedge CLK);
		REC_VALID <= 1'b0;
	endtask
endmodule

//--- verification/cprd_top_tb.sv
`timescale 1ns/1ns
module cprd_top_tb
	import cprd_pkg::*;
;
	logic         clk = 1'b0;
	logic         reset_n = 1'b0;
	logic         rec_start, rec_valid, rec_end;
	logic [15:0]  rec_index;
	logic [7:0]   rec_data;
	logic         fresh_assign = 1'b1;
	cprd_status_s status;
	cprd_cfg_s    cfg, cfg_exp = '0;
	logic         cfg_valid, cfgv_exp = 1'b0;
	logic [7:0]   gh[7];   // Header bytes of the next record
	int           errors = 0, total_checks = 0, cyc = 0;
	int           answers = 0, ans_base = 0;   // Answer strobes seen, and count at scenario start
	always #2 clk = ~clk;
	cprd_ctrl_model u_cprd_ctrl_model (.CLK(clk), .REC_START(rec_start), .REC_INDEX(rec_index),
		.REC_VALID(rec_valid), .REC_DATA(rec_data), .REC_END(rec_end));
	cprd_top u_cprd_top (.CLK(clk), .RESET_N(reset_n), .REC_START(rec_start), .REC_INDEX(rec_index),
		.REC_VALID(rec_valid), .REC_DATA(rec_data), .REC_END(rec_end), .FRESH_ASSIGN(fresh_assign),
		.STATUS(status), .CFG(cfg), .CFG_VALID(cfg_valid));
	task automatic wrap_up();
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard, far above the expected run
	always @(posedge clk)
	begin
		cyc++;
		// Answer strobes, read before this edge updates them
		if (status.valid === 1'b1)
			answers++;
		if (cyc == 20000)
		begin
			errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	// First fault wins, in record byte order
	function automatic logic [7:0] exp_code(logic [15:0] idx, int n, logic [7:0] hb[7], logic fresh);
		if (idx !== 16'h0080) return 8'hB0;
		if (hb[0] !== 8'h01 || hb[1] !== 8'h30 || hb[2] !== 8'h00 || hb[3] !== 8'h00) return 8'hB2;
		if (cfgv_exp && !fresh && hb[4][3:0] !== cfg_exp.func_mode) return 8'hB4;
		if (hb[4][7:4] != 4'h0 || !(hb[4][3:0] inside {4'h1, 4'h2}) || !(hb[5][1:0] inside {2'h1, 2'h2})
			|| hb[6][7:6] == 2'h3 || hb[6][5:4] == 2'h3 || hb[6][3:0] > 4'h4) return 8'hB3;
		if (n != 48) return 8'hB1;
		return 8'h30;
	endfunction
	// Good header repeating the applied config, one byte replaced
	function automatic void mk(int p, logic [7:0] v);
		gh = '{8'h01, 8'h30, 8'h00, 8'h00, {4'h0, cfg_exp.func_mode}, {6'h0, cfg_exp.stop_react}, cfg_exp[7:0]};
		gh[p] = v;
	endfunction
	task automatic run(input logic [15:0] idx, input int n, input logic fresh, input int stall);
		logic [7:0] code;
		@(posedge clk);
		fresh_assign <= fresh;
		code = exp_code(idx, n, gh, fresh);
		u_cprd_ctrl_model.write_rec(idx, gh, n, stall);
		#1;
		chk(16'(status), 16'({1'b1, code != 8'h30, code}));
		if (code == 8'h30)
		begin
			cfg_exp = {gh[4][3:0], gh[5][1:0], gh[6]};
			cfgv_exp = 1'b1;
		end
		chk(16'(cfg), 16'(cfg_exp));
		chk(16'(cfg_valid), 16'(cfgv_exp));
	endtask
	initial
	begin
		void'($urandom(32'hf9cb_0668));
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		// Every legal code of every field
		for (int s = 0; s < 5; s++)
		begin
			mk(4, 8'(s % 2 + 1));
			gh[5] = 8'(s % 2 + 1);
			gh[6] = {2'(s % 3), 2'((s + 1) % 3), 4'(s)};
			run(16'h0080, 48, 1'b1, s % 3);
		end
		run(16'h0081, 48, 1'b0, 0);
		mk(0, 8'h11);
		run(16'h0080, 48, 1'b0, 0);
		mk(1, 8'h2F);
		run(16'h0080, 48, 1'b0, 1);
		mk(3, 8'h40);
		run(16'h0080, 48, 1'b0, 0);
		mk(2, 8'h00);
		run(16'h0080, 47, 1'b0, 0);
		run(16'h0080, 49, 1'b0, 0);
		mk(4, {4'h0, cfg_exp.func_mode ^ 4'h3});
		run(16'h0080, 48, 1'b0, 0);
		mk(4, {4'h1, cfg_exp.func_mode});
		run(16'h0080, 48, 1'b0, 0);
		mk(5, 8'h03);
		run(16'h0080, 48, 1'b0, 0);
		mk(4, {4'h0, cfg_exp.func_mode ^ 4'h3});
		run(16'h0080, 48, 1'b1, 0);
		// Stray strobes outside a record and a cut record give no answer
		@(posedge clk);
		#1;
		ans_base = answers;
		u_cprd_ctrl_model.stray_cut(8'h5A);
		mk(4, {4'h0, cfg_exp.func_mode});
		run(16'h0080, 48, 1'b0, 0);
		@(posedge clk);
		#1;
		chk(16'(answers - ans_base), 16'h0001);
		// Random mix of legal, reserved and moved fields
		for (int k = 0; k < 60; k++)
		begin
			mk(4, 8'($urandom_range(0, 3)));
			gh[5] = 8'($urandom);
			gh[6] = 8'($urandom);
			run(16'h0080, 48, 1'($urandom), $urandom_range(0, 2));
		end
		wrap_up();
	end
endmodule
